// file: hw/wwdt_pkg.sv
// Package for the windowed watchdog: register map, option fields, keys.
// Assumes a 32-bit APB slave and a static option byte strapped at reset.
package wwdt_pkg;

  // ==========================================================
  // Register map (printed offsets are indices; byte address = 4 x index)
  localparam int unsigned ADDR_W       = 22;
  localparam logic [19:0] IDX_OPTION   = 20'h000c0;
  localparam logic [19:0] IDX_SERVICE  = 20'hfffab;
  localparam logic [21:0] ADDR_OPTION  = {IDX_OPTION, 2'b00};
  localparam logic [21:0] ADDR_SERVICE = {IDX_SERVICE, 2'b00};

  // ==========================================================
  // Service key and readback values
  localparam logic [7:0] SERVICE_KEY  = 8'hac;
  localparam logic [7:0] SVC_RST_RUN  = 8'h9a;
  localparam logic [7:0] SVC_RST_STOP = 8'h1a;

  // ==========================================================
  // Option byte field positions
  localparam int unsigned OPT_IRQ_EN  = 7;
  localparam int unsigned OPT_WIN_HI  = 6;
  localparam int unsigned OPT_WIN_LO  = 5;
  localparam int unsigned OPT_RUN_EN  = 4;
  localparam int unsigned OPT_OVF_HI  = 3;
  localparam int unsigned OPT_OVF_LO  = 1;
  localparam int unsigned OPT_STBY_EN = 0;

  // ==========================================================
  // Field encodings
  localparam logic [2:0] OVF_SEL_64   = 3'h0;
  localparam logic [2:0] OVF_SEL_128  = 3'h1;
  localparam logic [2:0] OVF_SEL_256  = 3'h2;
  localparam logic [2:0] OVF_SEL_512  = 3'h3;
  localparam logic [2:0] OVF_SEL_2048 = 3'h4;
  localparam logic [1:0] WIN_SEL_50   = 2'h1;
  localparam logic [1:0] WIN_SEL_75   = 2'h2;

  // ==========================================================
  // Counter and reset cause layout
  localparam int unsigned CNT_W        = 17;
  localparam int unsigned CAUSE_WDT    = 4;
  localparam logic [7:0]  CAUSE_WDT_V  = 8'h10;

  // Life cycle of the watchdog
  typedef enum logic [1:0] {
    ST_WAIT_CFG,
    ST_STOPPED,
    ST_COUNTING,
    ST_TRIPPED
  } wwdt_state_t;

endpackage : wwdt_pkg

// file: hw/wwdt_top.sv
// Windowed watchdog timer with APB access to option and service registers.
// Assumes lsclk_in is a free low-speed oscillator, asynchronous to sys_clk,
// and that standby_in comes from sys_clk logic.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/100ps

module wwdt_top
  import wwdt_pkg::*;
(
  input  wire logic                        sys_clk,
  input  wire logic                        sys_rst,
  input  wire logic                        lsclk_in,
  input  wire logic [7:0]                  option_byte_in,
  input  wire logic                        standby_in,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [wwdt_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  input  wire logic [3:0]                  pstrb,
  input  wire logic                        bit_access_in,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  output logic                             interval_irq,
  output logic                             wdt_rst_req,
  output logic [7:0]                       reset_cause_set
);
  import wwdt_pkg::*;

  // ==========================================================
  // Decode helpers
  // Period in low-speed cycles for an overflow code
  function automatic logic [CNT_W-1:0] period_of(input logic [2:0] sel);
    logic [CNT_W-1:0] p;
    p = '0;
    case (sel)
      OVF_SEL_64:   p = 17'h00040;
      OVF_SEL_128:  p = 17'h00080;
      OVF_SEL_256:  p = 17'h00100;
      OVF_SEL_512:  p = 17'h00200;
      OVF_SEL_2048: p = 17'h00800;
      default:      p = 17'h00800; // Prohibited codes take the longest
    endcase
    return p;
  endfunction : period_of

  // Count at which the window opens
  function automatic logic [CNT_W-1:0] win_start_of(input logic [1:0] win,
                                                    input logic [CNT_W-1:0] p,
                                                    input logic stby);
    logic [CNT_W-1:0] s;
    s = '0;
    if (stby)
      case (win)
        WIN_SEL_50: s = p >> 1;
        WIN_SEL_75: s = p >> 2;
        default:    s = '0;
      endcase
    return s;
  endfunction : win_start_of

  // ==========================================================
  // State and configuration
  wwdt_state_t      state_r;
  wwdt_state_t      state_nxt;
  logic [7:0]       opt_r;
  logic [CNT_W-1:0] cnt_r;
  logic             first_done_r;
  logic             standby_d_r;
  logic             ls_s1_r;
  logic             ls_s2_r;
  logic             ls_s3_r;
  logic             ls_lvl_r;
  logic             ls_rise;
  logic             ls_fall;
  logic             pready_r;
  logic [31:0]      prdata_r;
  logic             pslverr_r;
  logic             irq_r;
  logic             rst_req_r;
  logic [7:0]       cause_r;

  // Option fields
  logic             irq_en;
  logic [1:0]       win_sel;
  logic             run_en;
  logic [2:0]       ovf_sel;
  logic             stby_en;
  logic [CNT_W-1:0] period;
  logic [CNT_W-1:0] win_start;
  logic [CNT_W-1:0] irq_point;
  logic [7:0]       svc_rst_val;

  assign irq_en      = opt_r[OPT_IRQ_EN];
  assign win_sel     = opt_r[OPT_WIN_HI:OPT_WIN_LO];
  assign run_en      = opt_r[OPT_RUN_EN];
  assign ovf_sel     = opt_r[OPT_OVF_HI:OPT_OVF_LO];
  assign stby_en     = opt_r[OPT_STBY_EN];
  assign period      = period_of(ovf_sel);
  assign win_start   = win_start_of(win_sel, period, stby_en);
  assign irq_point   = period - (period >> 2);
  assign svc_rst_val = run_en ? SVC_RST_RUN : SVC_RST_STOP;

  // ==========================================================
  // Low-speed clock synchroniser, three stages with agreement
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ls_s1_r  <= 1'b0;
      ls_s2_r  <= 1'b0;
      ls_s3_r  <= 1'b0;
      ls_lvl_r <= 1'b0;
    end
    else
    begin
      ls_s1_r <= lsclk_in;
      ls_s2_r <= ls_s1_r;
      ls_s3_r <= ls_s2_r;
      if (ls_s2_r == ls_s3_r)
      begin
        ls_lvl_r <= ls_s3_r;
      end
    end
  end

  // Edges of the agreed low-speed level
  assign ls_rise = (ls_s2_r == ls_s3_r) && ls_s3_r && !ls_lvl_r;
  assign ls_fall = (ls_s2_r == ls_s3_r) && !ls_s3_r && ls_lvl_r;

  // ==========================================================
  // APB decode
  logic acc;
  logic setup_acc;
  logic wr_svc;
  logic live;
  logic counting;
  logic in_closed;
  logic bad_wr;
  logic svc_ok;
  logic halted;
  logic wake;
  logic overflow;
  logic trip;

  assign setup_acc = psel && penable && !pready_r;
  assign acc       = psel && penable && pready_r;
  assign wr_svc    = acc && pwrite && (paddr == ADDR_SERVICE);
  assign live      = (state_r == ST_STOPPED) || (state_r == ST_COUNTING);
  assign counting  = (state_r == ST_COUNTING);
  // Window check is skipped for the first write after reset
  assign in_closed = counting && first_done_r && (cnt_r < win_start);

  // Error cases of a service write
  assign bad_wr = wr_svc && live && (bit_access_in
                  || !pstrb[0]
                  || (pwdata[7:0] != SERVICE_KEY)
                  || in_closed);
  assign svc_ok = wr_svc && counting && !bad_wr;

  // Standby halting only when standby operation is off
  assign halted = standby_in && !stby_en;
  assign wake   = standby_d_r && !standby_in && !stby_en;

  // Overflow on the edge that would pass the last count
  assign overflow = counting && ls_rise && !halted && !svc_ok
                    && (cnt_r == period - 17'h00001);
  assign trip     = overflow || bad_wr;

  // ==========================================================
  // State machine
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_WAIT_CFG: state_nxt = option_byte_in[OPT_RUN_EN] ? ST_COUNTING : ST_STOPPED;
      ST_STOPPED:  state_nxt = bad_wr ? ST_TRIPPED : ST_STOPPED;
      ST_COUNTING: state_nxt = trip ? ST_TRIPPED : ST_COUNTING;
      ST_TRIPPED:  state_nxt = ST_TRIPPED;
      default:     state_nxt = ST_TRIPPED;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r <= ST_WAIT_CFG;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Option byte strap caught on the first edge after reset release
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      opt_r <= 8'h00;
    end
    else if (state_r == ST_WAIT_CFG)
    begin
      opt_r <= option_byte_in;
    end
  end

  // ==========================================================
  // Counter
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_r <= '0;
    end
    else if (counting)
    begin
      if (svc_ok || wake)
      begin
        cnt_r <= '0;
      end
      else if (ls_rise && !halted)
      begin
        cnt_r <= cnt_r + 17'h00001;
      end
    end
  end

  // First-write tracker and standby history
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      first_done_r <= 1'b0;
      standby_d_r  <= 1'b0;
    end
    else
    begin
      standby_d_r <= standby_in;
      if (svc_ok)
      begin
        first_done_r <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Events toward interrupt and reset controllers
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irq_r     <= 1'b0;
      rst_req_r <= 1'b0;
      cause_r   <= 8'h00;
    end
    else
    begin
      // Half a low-speed cycle after reaching the 75% count
      irq_r     <= counting && irq_en && ls_fall && !halted
                   && (cnt_r == irq_point) && !svc_ok;
      rst_req_r <= live && trip;
      cause_r   <= (live && trip) ? CAUSE_WDT_V : 8'h00;
    end
  end

  // ==========================================================
  // APB slave, one wait state
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r  <= setup_acc;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
      if (setup_acc)
      begin
        if (paddr == ADDR_SERVICE)
        begin
          prdata_r[7:0] <= pwrite ? 8'h00 : svc_rst_val;
        end
        else if (paddr == ADDR_OPTION)
        begin
          prdata_r[7:0] <= pwrite ? 8'h00 : opt_r;
          pslverr_r     <= pwrite; // Option byte is read only
        end
        else
        begin
          pslverr_r <= 1'b1; // Unmapped address
        end
      end
    end
  end

  assign prdata          = prdata_r;
  assign pready          = pready_r;
  assign pslverr         = pslverr_r;
  assign interval_irq    = irq_r;
  assign wdt_rst_req     = rst_req_r;
  assign reset_cause_set = cause_r;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_service_write;
    wr_svc && counting && !bad_wr;
  endsequence

  sequence s_bad_write;
    wr_svc && live && (pwdata[7:0] != SERVICE_KEY);
  endsequence

  a_tick_only_count: assert property (counting && !ls_rise && !svc_ok && !wake
    |=> $stable(cnt_r)) else $error("counter moved without low-speed edge");
  a_count_limit: assert property (cnt_r < period || !counting)
    else $error("counter passed period");
  a_overflow_reset: assert property (overflow |=> wdt_rst_req
    && state_r == ST_TRIPPED) else $error("overflow gave no reset");
  a_bit_access_rst: assert property (wr_svc && live && bit_access_in
    |=> wdt_rst_req) else $error("bit access gave no reset");
  a_bad_key_rst: assert property (s_bad_write |=> wdt_rst_req ##1 !wdt_rst_req)
    else $error("wrong key gave no reset");
  a_closed_window: assert property (wr_svc && in_closed |=> wdt_rst_req)
    else $error("closed window write gave no reset");
  a_service_clear: assert property (s_service_write |=> cnt_r == '0)
    else $error("service did not clear counter");
  a_cause_flag: assert property (wdt_rst_req |-> reset_cause_set[CAUSE_WDT])
    else $error("cause bit missing");
  a_irq_point: assert property (interval_irq |-> irq_en
    && $past(cnt_r) == irq_point && $past(ls_fall)) else $error("interrupt off point");
  a_key_readback: assert property (acc && !pwrite && paddr == ADDR_SERVICE
    |-> prdata[7:0] == svc_rst_val) else $error("service read wrong");
  a_stopped_hold: assert property (state_r == ST_STOPPED |=> cnt_r == '0)
    else $error("stopped counter moved");
  a_halt_hold: assert property (counting && halted && !svc_ok
    |=> $stable(cnt_r)) else $error("counter ran in standby");
  a_req_pulse: assert property (wdt_rst_req |=> !wdt_rst_req)
    else $error("reset request longer than one cycle");

endmodule : wwdt_top

// file: test/wwdt_bench.sv
// Self-checking bench for the windowed watchdog top level.
// Assumes wwdt_pkg and wwdt_top are compiled first; bench drives every input.
`timescale 1ns/100ps

module windowed_watchdog_timer_bench;
  import wwdt_pkg::*;

  // ==========================================================
  // Stimulus, observation and model state
  logic              sys_clk;
  logic              sys_rst;
  logic              lsclk_in;
  logic [7:0]        option_byte_in;
  logic              standby_in;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [3:0]        pstrb;
  logic              bit_access_in;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              interval_irq;
  logic              wdt_rst_req;
  logic [7:0]        reset_cause_set;
  int                failures = 0;
  int                tests_run = 0;
  int                seed = 46;
  int                ls_rises = 0;
  int                ls_base = 0;
  int                rst_seen = 0;
  int                rst_at = 0;
  int                irq_seen = 0;
  int                irq_at = 0;
  int                p;
  logic [31:0]       rd;
  logic              err;
  logic [31:0]       r;

  wwdt_top dut_u (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .lsclk_in(lsclk_in),
    .option_byte_in(option_byte_in), .standby_in(standby_in), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .bit_access_in(bit_access_in), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .interval_irq(interval_irq),
    .wdt_rst_req(wdt_rst_req), .reset_cause_set(reset_cause_set)
  );

  // ==========================================================
  // Clocks: 5 ns system clock, free low-speed clock of 82 ns
  // The low-speed edges never meet a rising system edge, so no sampling race
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  initial
  begin
    lsclk_in = 1'b0;
    forever #41 lsclk_in = ~lsclk_in;
  end

  // Model time base: low-speed rises since the last mark
  always @(posedge lsclk_in) ls_rises++;

  // Record reset requests and interval interrupts
  always @(posedge sys_clk)
  begin
    if (wdt_rst_req === 1'b1)
    begin
      rst_seen++;
      rst_at = ls_rises - ls_base;
      chk_ev(reset_cause_set, CAUSE_WDT_V, "cause");
    end
    if (interval_irq === 1'b1)
    begin
      irq_seen++;
      irq_at = ls_rises - ls_base;
    end
  end

  // ==========================================================
  // Compare tasks
  task automatic fail(input string what);
    failures++;
    $display("[ERR] %0t %s", $time, what);
  endtask : fail

  task automatic chk_rd(input logic [31:0] e_d, input logic e_err, input string what);
    tests_run++;
    if (rd !== e_d || err !== e_err)
      fail(what);
  endtask : chk_rd

  task automatic chk_ev(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp)
      fail(what);
  endtask : chk_ev

  task automatic chk_at(input int got, input int exp, input string what);
    tests_run++;
    if (got < exp - 1 || got > exp + 1)
      fail(what);
  endtask : chk_at

  // ==========================================================
  // Bus and sequencing helpers
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic ba);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel          <= 1'b1;
    penable       <= 1'b0;
    pwrite        <= wr;
    paddr         <= a;
    pwdata        <= d;
    pstrb         <= s;
    bit_access_in <= ba;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
      fail("no pready");
    rd = prdata;
    err = pslverr;
    psel          <= 1'b0;
    penable       <= 1'b0;
    bit_access_in <= 1'b0;
  endtask : apb

  task automatic svc(input logic [31:0] d);
    apb(1'b1, ADDR_SERVICE, d, 4'hf, 1'b0);
  endtask : svc

  task automatic do_reset(input logic [7:0] opt);
    @(posedge sys_clk);
    option_byte_in <= opt;
    sys_rst        <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    ls_base = ls_rises;
    rst_seen = 0;
    irq_seen = 0;
    @(posedge sys_clk);
  endtask : do_reset

  // Waits n low-speed rises, leaving early on a reset request
  task automatic wait_rises(input int n);
    int b;
    b = ls_rises;
    while (ls_rises - b < n && rst_seen == 0)
      @(posedge sys_clk);
    repeat (6) @(posedge sys_clk);
  endtask : wait_rises

  task automatic win_try(input logic [7:0] opt, input int at, input logic [31:0] exp);
    do_reset(opt);
    svc({24'h0, SERVICE_KEY});
    wait_rises(at);
    chk_ev(rst_seen, 0, "first service");
    svc({24'h0, SERVICE_KEY});
    repeat (4) @(posedge sys_clk);
    chk_ev(rst_seen, exp, "window");
  endtask : win_try

  task automatic bad(input logic [7:0] opt, input logic [31:0] d, input logic [3:0] s,
                     input logic ba);
    do_reset(opt);
    apb(1'b1, ADDR_SERVICE, d, s, ba);
    repeat (4) @(posedge sys_clk);
    chk_ev(rst_seen, 1, "bad write");
  endtask : bad

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  // ==========================================================
  // Watchdog against a hung run
  initial
  begin
    // Tests need about 300 us; this leaves half as much again, under 100k cycles
    #450000;
    fail("timeout");
    give_verdict();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    sys_rst = 1'b1;
    option_byte_in = 8'h10;
    standby_in = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
    bit_access_in = 1'b0;
    // Register map, readback and refused accesses
    do_reset(8'hb3);
    apb(1'b0, ADDR_SERVICE, 32'h0, 4'hf, 1'b0);
    chk_rd({24'h0, SVC_RST_RUN}, 1'b0, "svc reset");
    svc({24'h0, SERVICE_KEY});
    apb(1'b0, ADDR_SERVICE, 32'h0, 4'hf, 1'b0);
    chk_rd({24'h0, SVC_RST_RUN}, 1'b0, "svc readback");
    apb(1'b1, ADDR_OPTION, $random(seed), 4'hf, 1'b0);
    chk_rd(32'h0, 1'b1, "option write");
    apb(1'b0, ADDR_OPTION, 32'h0, 4'hf, 1'b0);
    chk_rd(32'h0000_00b3, 1'b0, "option read");
    apb(1'b0, ADDR_SERVICE + 22'h4, 32'h0, 4'hf, 1'b0);
    chk_rd(32'h0, 1'b1, "unmapped");
    $display("test registers finished");
    // Counter stays stopped when the run bit is clear
    do_reset(8'h01);
    apb(1'b0, ADDR_SERVICE, 32'h0, 4'hf, 1'b0);
    chk_rd({24'h0, SVC_RST_STOP}, 1'b0, "svc stopped");
    wait_rises(80);
    chk_ev(rst_seen, 0, "stopped count");
    $display("test stopped finished");
    // Overflow and interval interrupt for each period code
    for (int c = 0; c < 5; c++)
    begin
      r = $random(seed);
      r[7] = (c == 1) ? 1'b1 : ((c == 2) ? 1'b0 : r[7]); // Both interrupt settings seen
      do_reset({r[7:5], 1'b1, c[2:0], r[0]});
      standby_in <= r[0];
      p = 1 << ((c == 4) ? 11 : c + 6);
      wait_rises(p + 4);
      standby_in <= 1'b0;
      chk_ev(rst_seen, 1, "overflow");
      chk_at(rst_at, p, "period");
      chk_ev(irq_seen, {31'h0, r[7]}, "irq count");
      if (r[7])
        chk_at(irq_at, p * 3 / 4, "irq time");
    end
    $display("test overflow finished");
    // Repeated service keeps the counter clear; standby-off forces full window
    do_reset(8'h30);
    repeat (8)
    begin
      wait_rises(10);
      r = $random(seed);
      svc({r[31:8], SERVICE_KEY});
    end
    chk_ev(rst_seen, 0, "serviced");
    ls_base = ls_rises;
    wait_rises(70);
    chk_at(rst_at, 64, "restart");
    $display("test service finished");
    // Window shares: closed and open points
    win_try(8'h31, 26, 1);
    win_try(8'h31, 38, 0);
    win_try(8'h51, 10, 1);
    win_try(8'h51, 22, 0);
    win_try(8'h71, 3, 0);
    $display("test window finished");
    // Illegal service accesses
    r = $random(seed);
    if (r[7:0] == SERVICE_KEY)
      r[0] = ~r[0];
    bad(8'h30, r, 4'hf, 1'b0);
    bad(8'h01, r, 4'hf, 1'b0);
    bad(8'h30, {24'h0, SERVICE_KEY}, 4'hf, 1'b1);
    bad(8'h30, {24'h0, SERVICE_KEY}, 4'he, 1'b0);
    $display("test illegal finished");
    // Standby halts the counter and wake-up clears it
    do_reset(8'h30);
    wait_rises(30);
    standby_in <= 1'b1;
    wait_rises(100);
    chk_ev(rst_seen, 0, "standby hold");
    standby_in <= 1'b0;
    ls_base = ls_rises;
    wait_rises(70);
    chk_at(rst_at, 64, "wake clear");
    $display("test standby finished");
    give_verdict();
  end

endmodule : windowed_watchdog_timer_bench
